// ---- hdl/fsrw_pkg.sv ----
// Constants, field positions and carrier types for the fail-safe, reset, wake and interrupt register bank.
// Assumes an 8-bit register port in front (serial configuration front end) on the same 20 MHz clock.
package fsrw_pkg;

    // Register port widths
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h010;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h061;
    localparam logic [11:0] OFS_WAKE_CFG    = 12'h040;
    localparam logic [11:0] OFS_LIMP_STATUS = 12'h076;
    localparam logic [11:0] OFS_FAIL_COUNT  = 12'h090;
    localparam logic [11:0] OFS_LIMP_CTRL   = 12'h091;
    localparam logic [11:0] OFS_SW_RESET    = 12'hFE0;

    // Field positions
    localparam int unsigned BIT_CAN_WAKE    = 6;
    localparam int unsigned BIT_OVERTEMP    = 5;
    localparam int unsigned BIT_SERIAL_FAIL = 4;
    localparam int unsigned FAIL_COUNT_LSB  = 6;

    // Reset key values
    localparam logic [7:0] KEY_ARM     = 8'h01;
    localparam logic [7:0] KEY_CONFIRM = 8'h80;

    // Limp output control codes
    localparam logic [1:0] LIMP_HIGHZ = 2'h0;
    localparam logic [1:0] LIMP_LOW   = 2'h1;

    // Defaults after startup, and the fail counter ceiling
    localparam logic [1:0] FAIL_COUNT_RST = 2'h0;
    localparam logic [1:0] LIMP_CTRL_RST  = 2'h0;
    localparam logic       WAKE_LONG_RST  = 1'b0;
    localparam logic [2:0] IRQ_EN_RST     = 3'h0;
    localparam logic [1:0] FAIL_COUNT_MAX = 2'h3;

    // Software reset sequence states
    typedef enum logic {
        FSRW_KEY_IDLE,
        FSRW_KEY_ARMED
    } fsrw_key_state_t;

    // Register access request from the serial front end
    typedef struct packed {
        logic                wr;     // Write strobe, one cycle
        logic                rd;     // Read strobe, one cycle
        logic [ADDR_W-1:0]   addr;   // Register offset
        logic [DATA_W-1:0]   wdata;  // Write data
    } fsrw_req_t;

    // Device-core events, one-cycle pulses
    typedef struct packed {
        logic boot_ok;            // Successful startup completed
        logic failsafe_state;     // Fail-safe mode entered
        logic boot_failure_state; // Boot failure entered
        logic off_entry;          // Off mode entered
        logic fail_count_increment;
        logic can_wake;           // CAN wake-up detected
        logic overtemp;           // Overtemperature shutdown
        logic serial_fail;        // Serial port failure
    } fsrw_evt_t;

    // Whole module state
    typedef struct packed {
        fsrw_key_state_t key;        // Reset key sequence
        logic [1:0]      failsafe_count;
        logic [1:0]      limp_out_ctrl;
        logic            wake_pulse_long;
        logic            can_wake_irq_en;
        logic            overtemp_irq_en;
        logic            serial_fail_irq_en;
        logic [2:0]      irq_status;     // {can_wake, overtemp, serial_fail}
        logic [1:0]      level_sync;     // Limp level synchroniser
        logic            limp_out;       // Pin output value
        logic            limp_oe;        // Pin output enable
        logic            sys_reset;      // Reset request pulse
        logic            irq;            // Interrupt line
        logic            rvalid;         // Read data valid
        logic [7:0]      rdata;          // Read data
    } fsrw_state_t;

endpackage : fsrw_pkg

// ---- hdl/fsrw_regs.sv ----
// Fail-safe counter, limp-home pin control, software reset key, wake pulse config and system irq enables.
// Assumes a same-clock register port from the serial front end and event pulses from the device core.
module fsrw_regs (
    input  wire logic                sys_clk_i,       // 20 MHz core clock
    input  wire logic                resetn_i,        // Async reset, active low
    input  wire fsrw_pkg::fsrw_req_t req_i,           // Register access
    input  wire fsrw_pkg::fsrw_evt_t evt_i,           // Core events
    input  wire logic                limp_level_i,    // Sensed limp pin level, asynchronous
    output logic [7:0]               rdata_o,         // Read data
    output logic                     rvalid_o,        // Read data valid
    output logic                     limp_home_out_o, // Pin drive value
    output logic                     limp_home_oe_o,  // Pin drive enable
    output logic                     wake_pulse_long_o, // Long wake pulse selected
    output logic                     sys_reset_o,     // Software system reset pulse
    output logic                     irq_o            // Any pending interrupt
);

    // Reset release synchroniser
    logic [1:0]            rst_sync_r;   // Release shift register
    logic                  rst_n;        // Synchronised reset
    fsrw_pkg::fsrw_state_t st_r;         // Registered state
    fsrw_pkg::fsrw_state_t st_nxt;       // Next state
    logic [2:0]            irq_set;      // Enabled events this cycle
    logic [2:0]            irq_clr;      // Write-one-to-clear mask
    logic                  wr_key;       // Write to reset key register

    // Release asynchronous reset synchronously
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Next-state logic for the whole bank
    always_comb begin
        st_nxt           = st_r;
        st_nxt.sys_reset = 1'b0;
        st_nxt.rvalid    = 1'b0;
        irq_set = {evt_i.can_wake    & st_r.can_wake_irq_en,
                   evt_i.overtemp    & st_r.overtemp_irq_en,
                   evt_i.serial_fail & st_r.serial_fail_irq_en};
        irq_clr = 3'h0;
        wr_key  = req_i.wr && (req_i.addr == fsrw_pkg::OFS_SW_RESET);

        // Pin level passes two flops before use
        st_nxt.level_sync = {st_r.level_sync[0], limp_level_i};

        // Host writes
        if (req_i.wr) begin
            case (req_i.addr)
                fsrw_pkg::OFS_IRQ_ENABLE: begin
                    st_nxt.can_wake_irq_en    = req_i.wdata[fsrw_pkg::BIT_CAN_WAKE];
                    st_nxt.overtemp_irq_en    = req_i.wdata[fsrw_pkg::BIT_OVERTEMP];
                    st_nxt.serial_fail_irq_en = req_i.wdata[fsrw_pkg::BIT_SERIAL_FAIL];
                end
                fsrw_pkg::OFS_IRQ_STATUS: begin
                    // Only ones clear; zeros leave bits alone
                    irq_clr = {req_i.wdata[fsrw_pkg::BIT_CAN_WAKE],
                               req_i.wdata[fsrw_pkg::BIT_OVERTEMP],
                               req_i.wdata[fsrw_pkg::BIT_SERIAL_FAIL]};
                end
                fsrw_pkg::OFS_WAKE_CFG: begin
                    // Upper bits are not stored, so host junk there is harmless
                    st_nxt.wake_pulse_long = req_i.wdata[0];
                end
                fsrw_pkg::OFS_FAIL_COUNT: begin
                    st_nxt.failsafe_count = req_i.wdata[fsrw_pkg::FAIL_COUNT_LSB +: 2];
                end
                fsrw_pkg::OFS_LIMP_CTRL: begin
                    st_nxt.limp_out_ctrl = req_i.wdata[1:0];
                end
                default: begin
                    // Read-only, key or unmapped: nothing stored
                end
            endcase
        end

        // Software reset key sequence
        case (st_r.key)
            fsrw_pkg::FSRW_KEY_IDLE: begin
                if (wr_key && req_i.wdata == fsrw_pkg::KEY_ARM) begin
                    st_nxt.key = fsrw_pkg::FSRW_KEY_ARMED;
                end
            end
            fsrw_pkg::FSRW_KEY_ARMED: begin
                if (wr_key && req_i.wdata == fsrw_pkg::KEY_CONFIRM) begin
                    st_nxt.key       = fsrw_pkg::FSRW_KEY_IDLE;
                    st_nxt.sys_reset = 1'b1;
                end else if (wr_key && req_i.wdata == fsrw_pkg::KEY_ARM) begin
                    st_nxt.key = fsrw_pkg::FSRW_KEY_ARMED;
                end else if (req_i.wr) begin
                    // Any stray write cancels the armed reset
                    st_nxt.key = fsrw_pkg::FSRW_KEY_IDLE;
                end
            end
            default: begin
                st_nxt.key = fsrw_pkg::FSRW_KEY_IDLE;
            end
        endcase

        // Counter increment saturates rather than wrapping to zero
        if (evt_i.fail_count_increment && st_r.failsafe_count != fsrw_pkg::FAIL_COUNT_MAX) begin
            st_nxt.failsafe_count = st_r.failsafe_count + 2'h1;
        end

        // Drive-high codes do not survive increment or software reset
        if ((evt_i.fail_count_increment || st_nxt.sys_reset) && st_r.limp_out_ctrl[1]) begin
            st_nxt.limp_out_ctrl = fsrw_pkg::LIMP_CTRL_RST;
        end

        // Startup defaults reapplied at boot completion
        if (evt_i.boot_ok) begin
            st_nxt.failsafe_count     = fsrw_pkg::FAIL_COUNT_RST;
            st_nxt.wake_pulse_long    = fsrw_pkg::WAKE_LONG_RST;
            st_nxt.can_wake_irq_en    = fsrw_pkg::IRQ_EN_RST[2];
            st_nxt.overtemp_irq_en    = fsrw_pkg::IRQ_EN_RST[1];
            st_nxt.serial_fail_irq_en = fsrw_pkg::IRQ_EN_RST[0];
            st_nxt.limp_out_ctrl      = fsrw_pkg::LIMP_CTRL_RST;
        end

        // Mode entries override host writes in the same cycle
        if (evt_i.off_entry) begin
            st_nxt.limp_out_ctrl = fsrw_pkg::LIMP_HIGHZ;
        end
        if (evt_i.failsafe_state || evt_i.boot_failure_state) begin
            st_nxt.limp_out_ctrl = fsrw_pkg::LIMP_LOW;
        end
        if (evt_i.failsafe_state) begin
            st_nxt.failsafe_count = fsrw_pkg::FAIL_COUNT_RST;
        end

        // Set wins over a simultaneous clear
        st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;
        st_nxt.irq        = |st_nxt.irq_status;

        // Pin drive from the control code: 00 Z, 01 low, 1x high
        st_nxt.limp_oe  = (st_nxt.limp_out_ctrl != fsrw_pkg::LIMP_HIGHZ);
        st_nxt.limp_out = st_nxt.limp_out_ctrl[1];

        // Registered read data; reserved, key and unmapped read zero
        if (req_i.rd) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = 8'h00;
            case (req_i.addr)
                fsrw_pkg::OFS_IRQ_ENABLE: begin
                    st_nxt.rdata[fsrw_pkg::BIT_CAN_WAKE]    = st_r.can_wake_irq_en;
                    st_nxt.rdata[fsrw_pkg::BIT_OVERTEMP]    = st_r.overtemp_irq_en;
                    st_nxt.rdata[fsrw_pkg::BIT_SERIAL_FAIL] = st_r.serial_fail_irq_en;
                end
                fsrw_pkg::OFS_IRQ_STATUS: begin
                    st_nxt.rdata[fsrw_pkg::BIT_CAN_WAKE]    = st_r.irq_status[2];
                    st_nxt.rdata[fsrw_pkg::BIT_OVERTEMP]    = st_r.irq_status[1];
                    st_nxt.rdata[fsrw_pkg::BIT_SERIAL_FAIL] = st_r.irq_status[0];
                end
                fsrw_pkg::OFS_WAKE_CFG: begin
                    st_nxt.rdata[0] = st_r.wake_pulse_long;
                end
                fsrw_pkg::OFS_LIMP_STATUS: begin
                    st_nxt.rdata[0] = st_r.level_sync[1];
                end
                fsrw_pkg::OFS_FAIL_COUNT: begin
                    st_nxt.rdata[fsrw_pkg::FAIL_COUNT_LSB +: 2] = st_r.failsafe_count;
                end
                fsrw_pkg::OFS_LIMP_CTRL: begin
                    st_nxt.rdata[1:0] = st_r.limp_out_ctrl;
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register; reset values match the startup defaults
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata_o           = st_r.rdata;
    assign rvalid_o          = st_r.rvalid;
    assign limp_home_out_o   = st_r.limp_out;
    assign limp_home_oe_o    = st_r.limp_oe;
    assign wake_pulse_long_o = st_r.wake_pulse_long;
    assign sys_reset_o       = st_r.sys_reset;
    assign irq_o             = st_r.irq;

endmodule : fsrw_regs

// ---- bench/fsrw_regs_asserts.sv ----
// Checker for the fail-safe register bank, bound to the fsrw_regs ports.
// Assumes no request or event before internal reset release.
module fsrw_regs_asserts (
    input wire logic                sys_clk_i,
    input wire logic                resetn_i,
    input wire fsrw_pkg::fsrw_req_t req_i,
    input wire fsrw_pkg::fsrw_evt_t evt_i,
    input wire logic                limp_level_i,
    input wire logic                rvalid_o,
    input wire logic                limp_home_out_o,
    input wire logic                limp_home_oe_o,
    input wire logic                wake_pulse_long_o,
    input wire logic                sys_reset_o,
    input wire logic                irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic calm;  // No core event this cycle
    logic wr_fe; // Write to the reset key
    logic wr_in; // Write to a plain register
    assign calm  = (evt_i == '0);
    assign wr_fe = req_i.wr && (req_i.addr == 12'hFE0);
    assign wr_in = req_i.wr && (req_i.addr != 12'hFE0);
    logic [2:0] en_r; // Shadow of the three interrupt enables
    // Shadow follows host writes; boot completion restores zeros and beats a write
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_r <= 3'h0;
        end else if (evt_i.boot_ok) begin
            en_r <= 3'h0;
        end else if (req_i.wr && req_i.addr == fsrw_pkg::OFS_IRQ_ENABLE) begin
            en_r <= {req_i.wdata[fsrw_pkg::BIT_CAN_WAKE],
                     req_i.wdata[fsrw_pkg::BIT_OVERTEMP],
                     req_i.wdata[fsrw_pkg::BIT_SERIAL_FAIL]};
        end
    end
    // Key writes two cycles apart, as the host model issues them
    sequence s_arm;
        wr_fe && req_i.wdata == 8'h01 ##1 !req_i.wr;
    endsequence
    property p_rd;
        req_i.rd |=> rvalid_o;
    endproperty
    property p_ctrl_wr;
        req_i.wr && req_i.addr == 12'h091 && calm && req_i.wdata[1:0] != 2'h0
            |=> limp_home_oe_o && limp_home_out_o == $past(req_i.wdata[1]);
    endproperty
    property p_fs;
        evt_i.failsafe_state || evt_i.boot_failure_state |=> limp_home_oe_o && !limp_home_out_o;
    endproperty
    property p_off;
        evt_i.off_entry && !evt_i.failsafe_state && !evt_i.boot_failure_state |=> !limp_home_oe_o;
    endproperty
    property p_inc;
        evt_i.fail_count_increment && !evt_i.failsafe_state && !evt_i.boot_failure_state
            && !req_i.wr && limp_home_oe_o && limp_home_out_o |=> !limp_home_oe_o;
    endproperty
    property p_boot;
        evt_i.boot_ok && !evt_i.failsafe_state && !evt_i.boot_failure_state && !req_i.wr
            |=> !wake_pulse_long_o && !limp_home_oe_o;
    endproperty
    property p_wake;
        req_i.wr && req_i.addr == 12'h040 && calm |=> wake_pulse_long_o == $past(req_i.wdata[0]);
    endproperty
    property p_key;
        s_arm ##1 wr_fe && req_i.wdata == 8'h80 |=> sys_reset_o ##1 !sys_reset_o;
    endproperty
    property p_abandon;
        s_arm ##1 wr_in ##1 !req_i.wr ##1 wr_fe && req_i.wdata == 8'h80 |=> !sys_reset_o;
    endproperty
    property p_irq;
        $rose(irq_o) |-> $past((evt_i.can_wake && en_r[2]) || (evt_i.overtemp && en_r[1])
                               || (evt_i.serial_fail && en_r[0]));
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("limp pin ignores control write");
    a_fs: assert property (p_fs) else $error("limp pin not low after failure");
    a_off: assert property (p_off) else $error("limp pin driven after off");
    a_inc: assert property (p_inc) else $error("high code kept after increment");
    a_boot: assert property (p_boot) else $error("defaults not applied on boot");
    a_wake: assert property (p_wake) else $error("wake width not updated");
    a_key: assert property (p_key) else $error("reset key sequence not obeyed");
    a_abandon: assert property (p_abandon) else $error("broken key sequence reset");
    a_irq: assert property (p_irq) else $error("irq without event");
    c_reset: cover property (sys_reset_o);
    c_irq: cover property ($rose(irq_o));
    c_fs: cover property (evt_i.failsafe_state);
endmodule : fsrw_regs_asserts

// ---- bench/fsrw_host.sv ----
// Host model: register requests at the falling edge, and the limp pin wire.
// Assumes the bench waits out the reset release before the first call.
module fsrw_host (
    input  wire logic           sys_clk_i,
    input  wire logic [7:0]     rdata_i,
    input  wire logic           rvalid_i,
    input  wire logic           pin_oe_i,
    input  wire logic           pin_out_i,
    output fsrw_pkg::fsrw_req_t req_o,
    output logic                level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Board pull-up lifts the pin while the device leaves it floating
    assign level_o = pin_oe_i ? pin_out_i : 1'b1;
    initial req_o = '0;
    // One-cycle write strobe, then a quiet cycle
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        if (a == 12'h040) d[7:1] = 7'h00;
        @(negedge sys_clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk_i);
        req_o = '0;
    endtask : wr
    // Read strobe; data is taken while the valid pulse stands
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk_i);
        // Valid stands for one cycle only, so take the data before dropping the strobe
        d     = rvalid_i ? rdata_i : 8'hxx;
        req_o = '0;
    endtask : rd
    // Arm then confirm; a stray write between them when ok is low
    task automatic sw_reset(input logic ok);
        wr(12'hFE0, 8'h01);
        if (!ok) wr(12'h091, 8'h00);
        wr(12'hFE0, 8'h80);
    endtask : sw_reset
endmodule : fsrw_host

// ---- bench/fsrw_regs_tb.sv ----
// Self-checking bench for fsrw_regs, driven through the host model.
// Assumes a 20 MHz clock; the checker is bound at the foot.
module fsrw_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                sys_clk_i = 1'b0;
    logic                resetn_i  = 1'b0;
    fsrw_pkg::fsrw_req_t req;
    fsrw_pkg::fsrw_evt_t evt       = '0;
    logic [7:0]          rdata;
    logic                rvalid, oe, out, wake, sreset, irq, level;
    int                  err_count = 0;
    int                  checked   = 0;
    int                  resets    = 0; // Reset pulses seen
    logic [11:0]         regs [7]  = '{12'h010, 12'h040, 12'h090, 12'h091, 12'h061, 12'hFE0, 12'h123};
    initial forever #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (sreset === 1'b1) resets++;
    fsrw_regs dut (.sys_clk_i, .resetn_i, .req_i(req), .evt_i(evt), .limp_level_i(level),
        .rdata_o(rdata), .rvalid_o(rvalid), .limp_home_out_o(out), .limp_home_oe_o(oe),
        .wake_pulse_long_o(wake), .sys_reset_o(sreset), .irq_o(irq));
    fsrw_host host (.sys_clk_i, .rdata_i(rdata), .rvalid_i(rvalid), .pin_oe_i(oe),
        .pin_out_i(out), .req_o(req), .level_o(level));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] g;
        host.rd(a, g);
        chk($sformatf("reg %h", a), e, g);
    endtask : rchk
    // One-cycle core event pulse; pins are looked at a cycle later, irq two cycles later
    task automatic ev(input logic [7:0] m);
        @(negedge sys_clk_i);
        evt = fsrw_pkg::fsrw_evt_t'(m);
        @(negedge sys_clk_i);
        evt = '0;
    endtask : ev
    task automatic pin(input logic [7:0] e);
        chk("pin", e, {6'h00, oe, oe & out});
    endtask : pin
    task automatic irq_chk(input logic e);
        @(negedge sys_clk_i);
        chk("irq", {7'h00, e}, {7'h00, irq});
    endtask : irq_chk
    task automatic complete_run;
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(2000 * 50);
        err_count++;
        complete_run;
    end
    initial begin
        repeat (4) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        foreach (regs[i]) rchk(regs[i], 8'h00);
        host.wr(12'h010, 8'h70);
        rchk(12'h010, 8'h70);
        host.wr(12'h040, 8'hFF);
        chk("wake", 8'h01, {7'h00, wake});
        for (int c = 0; c < 4; c++) begin
            host.wr(12'h091, 8'(c));
            pin((c == 0) ? 8'h00 : ((c == 1) ? 8'h02 : 8'h03));
            repeat (2) @(negedge sys_clk_i);
            rchk(12'h076, {7'h00, c != 1});
        end
        ev(8'h04);
        irq_chk(1'b1);
        host.wr(12'h061, 8'h00);
        irq_chk(1'b1);
        host.wr(12'h061, 8'h40);
        irq_chk(1'b0);
        host.wr(12'h010, 8'h50);
        ev(8'h02);
        irq_chk(1'b0);
        ev(8'h01);
        rchk(12'h061, 8'h10);
        host.wr(12'h090, 8'hC0);
        rchk(12'h090, 8'hC0);
        ev(8'h40);
        pin(8'h02);
        rchk(12'h090, 8'h00);
        host.wr(12'h091, 8'h03);
        ev(8'h08);
        rchk(12'h091, 8'h00);
        rchk(12'h090, 8'h40);
        ev(8'h30);
        pin(8'h02);
        ev(8'h10);
        pin(8'h00);
        host.wr(12'h010, 8'h70);
        ev(8'h80);
        chk("wake", 8'h00, {7'h00, wake});
        rchk(12'h010, 8'h00);
        host.wr(12'h091, 8'h03);
        host.sw_reset(1'b1);
        repeat (2) @(negedge sys_clk_i);
        chk("resets", 8'h01, 8'(resets));
        pin(8'h00);
        host.sw_reset(1'b0);
        host.wr(12'hFE0, 8'h80);
        repeat (2) @(negedge sys_clk_i);
        chk("resets", 8'h01, 8'(resets));
        complete_run;
    end
endmodule : fsrw_regs_tb
bind fsrw_regs fsrw_regs_asserts chk (.sys_clk_i, .resetn_i, .req_i, .evt_i, .limp_level_i,
    .rvalid_o, .limp_home_out_o, .limp_home_oe_o, .wake_pulse_long_o, .sys_reset_o, .irq_o);
